/* rtl/gpp_port.sv */
`include "gpp_defines.svh"

module gpp_port (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins
    input wire logic [7:0] gp_pins_i,
    output logic [7:0] gp_pins_o,
    output logic [7:0] gp_pins_oe_o,
    // timer interrupt from the timer block, same clock
    input wire logic timer_irq_i,
    // port request, the OR of the pending flags; a level read clears it, a status read does not
    output logic port_irq_ch0_o,
    output logic irq_o
);
    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic gpp_pkg::gpp_reg_t decode(input logic [11:0] addr);
        case (addr)
            `GPP_OFS_INT_EN: decode = gpp_pkg::GPP_R_INT_EN;
            `GPP_OFS_LEVEL: decode = gpp_pkg::GPP_R_LEVEL;
            `GPP_OFS_TRI: decode = gpp_pkg::GPP_R_TRI;
            `GPP_OFS_INV: decode = gpp_pkg::GPP_R_INV;
            `GPP_OFS_DIR: decode = gpp_pkg::GPP_R_DIR;
            `GPP_OFS_TMR_CTL: decode = gpp_pkg::GPP_R_TMR_CTL;
            `GPP_OFS_IRQ_STS: decode = gpp_pkg::GPP_R_IRQ_STS;
            `GPP_OFS_IRQ_MSK: decode = gpp_pkg::GPP_R_IRQ_MSK;
            default: decode = gpp_pkg::GPP_R_NONE;
        endcase
    endfunction : decode

    gpp_pkg::gpp_cfg_t cfg_q;
    gpp_pkg::gpp_drive_t drv_d;
    gpp_pkg::gpp_drive_t drv_q;
    logic [7:0] tmr_ctl_q;
    logic [1:0] sts_q;
    logic [1:0] msk_q;
    logic [7:0] pin_sync;
    logic [7:0] pin_adj;
    logic [7:0] adj_prev_q;
    logic [7:0] edge_hit;
    logic [7:0] pend_q;
    logic [7:0] level_rd;
    logic [31:0] rdata_d;
    logic [31:0] prdata_q;
    logic setup;
    logic access;
    logic wr_en;
    logic rd_en;
    gpp_pkg::gpp_reg_t sel_acc;

    assign setup = psel && !penable;
    assign access = psel && penable;
    assign sel_acc = decode(paddr);
    assign wr_en = access && pwrite;
    assign rd_en = access && !pwrite;

    // zero wait states: read data are captured in the setup cycle
    assign pready = 1'b1;
    assign pslverr = access && (decode(paddr) == gpp_pkg::GPP_R_NONE);
    assign prdata = prdata_q;

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cfg_q.int_en <= `GPP_RST_INT_EN; // RULE4 RULE15
            cfg_q.level <= `GPP_RST_LEVEL; // RULE10 RULE15
            cfg_q.tri_st <= `GPP_RST_TRI; // RULE11 RULE15
            cfg_q.inv <= `GPP_RST_INV; // RULE12 RULE15
            cfg_q.dir <= `GPP_RST_DIR; // RULE3 RULE15
            tmr_ctl_q <= `GPP_RST_TMR_CTL;
            msk_q <= `GPP_RST_IRQ;
        end else if (wr_en) begin
            case (sel_acc)
                gpp_pkg::GPP_R_INT_EN: cfg_q.int_en <= pwdata[7:0];
                gpp_pkg::GPP_R_LEVEL: cfg_q.level <= pwdata[7:0];
                gpp_pkg::GPP_R_TRI: cfg_q.tri_st <= pwdata[7:0];
                gpp_pkg::GPP_R_INV: cfg_q.inv <= pwdata[7:0];
                gpp_pkg::GPP_R_DIR: cfg_q.dir <= pwdata[7:0];
                gpp_pkg::GPP_R_TMR_CTL: tmr_ctl_q <= {3'h0, pwdata[4:0]};
                gpp_pkg::GPP_R_IRQ_MSK: msk_q <= pwdata[1:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // input path and edge detection
    // ------------------------------------------------------------
    gpp_sync u_sync (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .async_i(gp_pins_i),
        .sync_o(pin_sync)
    );

    generate
        for (genvar i = 0; i < 8; i++) begin : g_pin
            // bit i of each of the five port registers belongs to pin i
            assign pin_adj[i] = pin_sync[i] ^ cfg_q.inv[i]; // RULE12 RULE2 RULE1
            // active-going edge of the adjusted level; inversion picks polarity
            assign edge_hit[i] = pin_adj[i] && !adj_prev_q[i]
                                 && cfg_q.int_en[i] && cfg_q.dir[i]; // RULE5 RULE4
            // inputs return their sampled state, outputs the level bit
            assign level_rd[i] = cfg_q.dir[i] ? pin_adj[i] : cfg_q.level[i]; // RULE9
        end
    endgenerate

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            adj_prev_q <= 8'h00;
        end else begin
            adj_prev_q <= pin_adj;
        end
    end

    // a new edge in the clearing cycle survives the read
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pend_q <= 8'h00;
        end else if (rd_en && sel_acc == gpp_pkg::GPP_R_LEVEL) begin
            pend_q <= edge_hit; // RULE8 RULE14
        end else begin
            pend_q <= pend_q | edge_hit; // RULE14
        end
    end

    assign port_irq_ch0_o = |pend_q; // RULE6 RULE7

    // ------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------
    // bit 0 flags the port request for channel 0; bit 1 (channel 1) never sets
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sts_q <= `GPP_RST_IRQ;
        end else if (rd_en && sel_acc == gpp_pkg::GPP_R_IRQ_STS) begin
            sts_q <= {1'b0, |edge_hit};
        end else begin
            sts_q[`GPP_STS_CH0_BIT] <= sts_q[`GPP_STS_CH0_BIT] | (|edge_hit); // RULE7
        end
    end

    assign irq_o = |(sts_q & msk_q);

    // ------------------------------------------------------------
    // read data, taken at setup so it is stable in the access phase
    // ------------------------------------------------------------
    always_comb begin
        rdata_d = 32'h0000_0000;
        case (decode(paddr))
            gpp_pkg::GPP_R_INT_EN: rdata_d[7:0] = cfg_q.int_en;
            gpp_pkg::GPP_R_LEVEL: rdata_d[7:0] = level_rd;
            gpp_pkg::GPP_R_TRI: rdata_d[7:0] = cfg_q.tri_st;
            gpp_pkg::GPP_R_INV: rdata_d[7:0] = cfg_q.inv;
            gpp_pkg::GPP_R_DIR: rdata_d[7:0] = cfg_q.dir;
            gpp_pkg::GPP_R_TMR_CTL: rdata_d[7:0] = tmr_ctl_q;
            gpp_pkg::GPP_R_IRQ_STS: rdata_d[1:0] = sts_q;
            gpp_pkg::GPP_R_IRQ_MSK: rdata_d[1:0] = msk_q;
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // output drivers
    // ------------------------------------------------------------
    always_comb begin
        drv_d.out = cfg_q.level; // RULE10
        drv_d.oe = ~(cfg_q.dir | cfg_q.tri_st); // RULE3 RULE11
        if (tmr_ctl_q[`GPP_TMR_ROUTE_BIT] && !cfg_q.dir[0]) begin
            drv_d.out[0] = timer_irq_i; // RULE13
        end
    end

    // pins stay undriven through reset since drv_q resets oe to zero, and after it since the direction resets to input
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            drv_q <= {8'h00, 8'h00}; // RULE15
        end else begin
            drv_q <= drv_d;
        end
    end

    assign gp_pins_o = drv_q.out;
    assign gp_pins_oe_o = drv_q.oe;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    a_oe_from_cfg: assert property ( // RULE11
        1'b1 |=> gp_pins_oe_o == ~($past(cfg_q.dir) | $past(cfg_q.tri_st)))
        else $error("output enable does not follow direction and tristate");

    a_out_level: assert property ( // RULE10
        1'b1 |=> gp_pins_o[7:1] == $past(cfg_q.level[7:1]))
        else $error("output level does not follow level register");

    a_timer_route: assert property ( // RULE13
        tmr_ctl_q[`GPP_TMR_ROUTE_BIT] && !cfg_q.dir[0] |=> gp_pins_o[0] == $past(timer_irq_i))
        else $error("timer interrupt not routed to pin 0");

    a_edge_pends: assert property ( // RULE14
        |edge_hit |=> port_irq_ch0_o && sts_q[`GPP_STS_CH0_BIT])
        else $error("detected edge did not raise the port request");

    a_level_rd_clr: assert property ( // RULE8
        rd_en && sel_acc == gpp_pkg::GPP_R_LEVEL && !(|edge_hit) |=> !port_irq_ch0_o)
        else $error("level read did not clear the port request");

    a_no_rd_hold: assert property ( // RULE14
        port_irq_ch0_o && !(rd_en && sel_acc == gpp_pkg::GPP_R_LEVEL) |=> port_irq_ch0_o)
        else $error("port request dropped without a level read");

    a_en_gates: assert property ( // RULE4
        ((pend_q & ~$past(pend_q)) & ~$past(cfg_q.int_en & cfg_q.dir)) == 8'h00)
        else $error("pending flag set on a disabled or output pin");

    a_level_data: assert property ( // RULE9
        setup && !pwrite && decode(paddr) == gpp_pkg::GPP_R_LEVEL
        |=> (prdata[7:0] & $past(cfg_q.dir)) == ($past(pin_adj) & $past(cfg_q.dir)))
        else $error("level read does not return input pin state");

    a_irq_mask: assert property ( // RULE7
        $rose(port_irq_ch0_o) && msk_q[`GPP_STS_CH0_BIT] |-> irq_o)
        else $error("unmasked port request did not raise the interrupt");

    c_edge_then_read: cover property (|edge_hit ##[1:20] (rd_en && sel_acc == gpp_pkg::GPP_R_LEVEL));
    c_timer_out: cover property (tmr_ctl_q[`GPP_TMR_ROUTE_BIT] && !cfg_q.dir[0] && timer_irq_i);
    c_irq_out: cover property ($rose(irq_o));
    c_bad_addr: cover property (pslverr);
endmodule : gpp_port

/* common/gpp_defines.svh */
`ifndef GPP_DEFINES_SVH
`define GPP_DEFINES_SVH
// Contract
// [RULE1] eight general pins, each set by software as input or output
// [RULE2] register bit n controls pin n, bit 7 pin 7 down to bit 0 pin 0
// [RULE3] direction bit one means input, zero output; resets to all ones
// [RULE4] interrupt enable acts only on input pins; enables reset to zero
// [RULE5] pin interrupts are edge detected; polarity set by inversion and level state
// [RULE6] requests of all enabled input pins are ORed into one port request
// [RULE7] the port request shows only in serial channel 0 interrupt status
// [RULE8] reading the level register clears the pending port interrupt
// [RULE9] level register read returns sampled state of input pins
// [RULE10] output pins drive the level bit, zero low, one high; level resets zero
// [RULE11] tristate bit zero drives output, one floats it; resets to zero
// [RULE12] inversion bit one inverts sampled input, zero passes it; resets zero
// [RULE13] timer route bit with pin 0 output drives timer interrupt onto pin 0
// [RULE14] inputs synchronised; active edge latches pending flag until level read
// [RULE15] reset returns all five port registers to defaults before driving pins

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define GPP_OFS_INT_EN  12'h000
`define GPP_OFS_LEVEL   12'h004
`define GPP_OFS_TRI     12'h008
`define GPP_OFS_INV     12'h00C
`define GPP_OFS_DIR     12'h010
`define GPP_OFS_TMR_CTL 12'h014
`define GPP_OFS_IRQ_STS 12'h018
`define GPP_OFS_IRQ_MSK 12'h01C

// ------------------------------------------------------------
// reset values and field positions
// ------------------------------------------------------------
`define GPP_RST_INT_EN  8'h00
`define GPP_RST_LEVEL   8'h00
`define GPP_RST_TRI     8'h00
`define GPP_RST_INV     8'h00
`define GPP_RST_DIR     8'hFF
`define GPP_RST_TMR_CTL 8'h00
`define GPP_RST_IRQ     2'h0
`define GPP_TMR_ROUTE_BIT 4
`define GPP_STS_CH0_BIT 0
`define GPP_SYNC_STAGES 2
`endif

/* common/gpp_pkg.sv */
package gpp_pkg;
    typedef enum logic [3:0] {
        GPP_R_INT_EN,
        GPP_R_LEVEL,
        GPP_R_TRI,
        GPP_R_INV,
        GPP_R_DIR,
        GPP_R_TMR_CTL,
        GPP_R_IRQ_STS,
        GPP_R_IRQ_MSK,
        GPP_R_NONE
    } gpp_reg_t;

    typedef struct packed {
        logic [7:0] int_en;
        logic [7:0] level;
        logic [7:0] tri_st;
        logic [7:0] inv;
        logic [7:0] dir;
    } gpp_cfg_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } gpp_drive_t;
endpackage : gpp_pkg

/* rtl/gpp_sync.sv */
// two-flop synchroniser per pin; first stage feeds only the second
module gpp_sync (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic [7:0] async_i,
    output logic [7:0] sync_o
);
    logic [7:0] meta_q;

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_q <= 8'h00;
            sync_o <= 8'h00;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule : gpp_sync

/* sim/gpp_pin_model.sv */
module gpp_pin_model (
    input wire logic [7:0] drv_i,
    input wire logic [7:0] oe_i,
    input wire logic [7:0] ext_i,
    output logic [7:0] pins_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // a driven pin reads back its own level, a released one follows the far side
    assign pins_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule : gpp_pin_model

/* sim/tb_top.sv */
`include "gpp_defines.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] gp_pins_i;
    logic [7:0] gp_pins_o;
    logic [7:0] gp_pins_oe_o;
    logic [7:0] ext_lvl = 8'h00;
    logic timer_irq_i = 1'b0;
    logic port_irq_ch0_o;
    logic irq_o;
    logic [31:0] rd;
    logic err;
    logic [7:0] dir;
    logic [7:0] tri_v;
    logic [7:0] lvl;
    logic [7:0] inv;
    int fail_count = 0;
    int cmp_count = 0;
    logic [11:0] ofs [8] = '{`GPP_OFS_INT_EN, `GPP_OFS_LEVEL, `GPP_OFS_TRI, `GPP_OFS_INV,
        `GPP_OFS_DIR, `GPP_OFS_TMR_CTL, `GPP_OFS_IRQ_STS, `GPP_OFS_IRQ_MSK};
    logic [7:0] rst [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00};

    always #50 clk_sys_i = ~clk_sys_i;

    gpp_port i_dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .gp_pins_i(gp_pins_i), .gp_pins_o(gp_pins_o), .gp_pins_oe_o(gp_pins_oe_o),
        .timer_irq_i(timer_irq_i), .port_irq_ch0_o(port_irq_ch0_o), .irq_o(irq_o));

    gpp_pin_model i_pins (.drv_i(gp_pins_o), .oe_i(gp_pins_oe_o), .ext_i(ext_lvl), .pins_o(gp_pins_i));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask : chk

    task apb(input logic wr, input logic [11:0] adr, input logic [31:0] dat);
        @(posedge clk_sys_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= adr;
        pwdata <= dat;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        do @(posedge clk_sys_i); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : cyc

    function automatic logic [7:0] f_oe(input logic [7:0] d, input logic [7:0] t);
        return ~d & ~t;
    endfunction : f_oe

    // input pins show the adjusted pin, output pins their level bit
    function automatic logic [7:0] f_lvl(input logic [7:0] d, l, v, e);
        return (d & (e ^ v)) | (~d & l);
    endfunction : f_lvl

    task test_done;
        $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        void'($urandom(96));
        cyc(2);
        reset_n_i <= 1'b1;
        foreach (ofs[i]) begin
            apb(1'b0, ofs[i], 32'h0000_0000);
            chk("reset value", {24'h00_0000, rst[i]}, rd);
        end
        chk("enable after reset", 8'h00, gp_pins_oe_o);
        apb(1'b1, 12'h020, 32'h0000_00FF);
        chk("unmapped error", 1'b1, err);
        apb(1'b0, 12'h020, 32'h0000_0000);
        chk("unmapped read", 32'h0000_0000, rd);
        repeat (6) begin
            {dir, tri_v, lvl, inv} = $urandom;
            ext_lvl <= 8'($urandom);
            apb(1'b1, `GPP_OFS_INV, {24'h00_0000, inv});
            apb(1'b1, `GPP_OFS_TRI, {24'h00_0000, tri_v});
            apb(1'b1, `GPP_OFS_LEVEL, {24'h00_0000, lvl});
            apb(1'b1, `GPP_OFS_DIR, {24'h00_0000, dir});
            apb(1'b0, `GPP_OFS_TRI, 32'h0000_0000);
            chk("tristate readback", {24'h00_0000, tri_v}, rd);
            cyc(3);
            chk("pin enable", f_oe(dir, tri_v), gp_pins_oe_o);
            chk("pin drive", lvl & f_oe(dir, tri_v), gp_pins_o & f_oe(dir, tri_v));
            apb(1'b0, `GPP_OFS_LEVEL, 32'h0000_0000);
            chk("level read", f_lvl(dir, lvl, inv, ext_lvl), rd[7:0]);
        end
        // pin 0 active high, pin 1 active low, pin 2 not enabled, pin 3 an output
        ext_lvl <= 8'h02;
        apb(1'b1, `GPP_OFS_TRI, 32'h0000_0000);
        apb(1'b1, `GPP_OFS_INV, 32'h0000_0002);
        apb(1'b1, `GPP_OFS_LEVEL, 32'h0000_0000);
        apb(1'b1, `GPP_OFS_DIR, 32'h0000_00F7);
        apb(1'b1, `GPP_OFS_IRQ_MSK, 32'h0000_0001);
        apb(1'b1, `GPP_OFS_INT_EN, 32'h0000_000B);
        cyc(4);
        apb(1'b0, `GPP_OFS_LEVEL, 32'h0000_0000);
        apb(1'b0, `GPP_OFS_IRQ_STS, 32'h0000_0000);
        for (int p = 0; p < 3; p++) begin
            ext_lvl <= ext_lvl ^ (8'h01 << p);
            cyc(4);
            chk("port request", p != 2, port_irq_ch0_o);
            chk("irq line", p != 2, irq_o);
            apb(1'b0, `GPP_OFS_IRQ_STS, 32'h0000_0000);
            chk("status", {31'h0000_0000, p != 2}, rd);
            cyc(1);
            chk("irq after status read", 1'b0, irq_o);
            chk("pending held", p != 2, port_irq_ch0_o);
            apb(1'b0, `GPP_OFS_LEVEL, 32'h0000_0000);
            cyc(1);
            chk("pending after level read", 1'b0, port_irq_ch0_o);
        end
        apb(1'b1, `GPP_OFS_LEVEL, 32'h0000_0008);
        cyc(4);
        chk("output pin request", 1'b0, port_irq_ch0_o);
        apb(1'b1, `GPP_OFS_IRQ_MSK, 32'h0000_0000);
        ext_lvl <= 8'h00;
        cyc(4);
        ext_lvl <= 8'h01;
        cyc(4);
        chk("masked request", 1'b1, port_irq_ch0_o);
        chk("masked irq line", 1'b0, irq_o);
        apb(1'b1, `GPP_OFS_DIR, 32'h0000_00FE);
        apb(1'b1, `GPP_OFS_TMR_CTL, 32'h0000_0010);
        timer_irq_i <= 1'b1;
        cyc(3);
        chk("timer on pin 0", 1'b1, gp_pins_o[0]);
        timer_irq_i <= 1'b0;
        cyc(3);
        chk("timer off pin 0", 1'b0, gp_pins_o[0]);
        test_done();
    end

    initial begin
        #(100 * 20000);
        fail_count++;
        test_done();
    end
endmodule : tb_top
